/* ppmrb_defs.svh */
// register offsets, field positions, reset values and timing counts
`ifndef PPMRB_DEFS_SVH
`define PPMRB_DEFS_SVH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define PPMRB_A_CTRL1   8'h00
`define PPMRB_A_STAT1   8'h04
`define PPMRB_A_ID1     8'h08
`define PPMRB_A_ID2     8'h0c
`define PPMRB_A_CTRL2   8'h10
`define PPMRB_A_STAT2   8'h14
`define PPMRB_A_TXDIS   8'h18
`define PPMRB_A_EXTAB   8'h1c
`define PPMRB_A_HSCTL   8'h20
`define PPMRB_A_HSSTAT  8'h24
`define PPMRB_A_ERRC0   8'h28

// ----------------------------------------
// field positions
// ----------------------------------------
`define PPMRB_B_SRST    15
`define PPMRB_B_LPWR    11
`define PPMRB_F_SPEED   5:2
`define PPMRB_B_RLB     1
`define PPMRB_B_LLB     0
`define PPMRB_B_RXLINK  2
`define PPMRB_B_FAULT   7
`define PPMRB_F_PRES    15:14
`define PPMRB_B_TXF     11
`define PPMRB_B_RXF     10
`define PPMRB_F_TYPE    5:0
`define PPMRB_F_TXDIS   10:0
`define PPMRB_B_TONE    0
`define PPMRB_B_IGN     1
`define PPMRB_B_CLRD    2
`define PPMRB_F_LSTATE  2:0

// ----------------------------------------
// reset values and timing
// ----------------------------------------
`define PPMRB_PRESENT   2'h2
`define PPMRB_TYPE_RST  6'h00
`define PPMRB_SRST_NS   320
`define PPMRB_CLK_NS    20
`define PPMRB_SRST_CYC  ((`PPMRB_SRST_NS+`PPMRB_CLK_NS-1)/`PPMRB_CLK_NS)
`define PPMRB_RST_MAX_NS 500000000

`endif

/* ppmrb_pkg.sv */
// types shared by the management register block
package ppmrb_pkg;

  typedef struct packed {
    logic       lowPwr;
    logic [3:0] speed;
    logic       remLoop;
    logic       locLoop;
  } ppmrb_ctrl_s;

  typedef struct packed {
    logic toneEn;
    logic ignoreTones;
    logic clearDown;
  } ppmrb_hs_s;

  typedef enum logic [1:0] {
    SR_IDLE = 2'b00,
    SR_HOLD = 2'b01,
    SR_DONE = 2'b11
  } ppmrb_srst_e;

  typedef enum logic [2:0] {
    LS_DOWN  = 3'b000,
    LS_INIT  = 3'b001,
    LS_UP    = 3'b010,
    LS_TONES = 3'b100
  } ppmrb_link_e;

endpackage : ppmrb_pkg

/* ppmrb_sat_cnt.sv */
// saturating error counter with clear
`timescale 1ns/1ns
module ppmrb_sat_cnt #(
  parameter int W = 16
) (
  // clock and reset
  input  wire logic         sys_clk,
  input  wire logic         rstn,
  // count control
  input  wire logic         clr,
  input  wire logic         inc,
  output logic [W-1:0]      count
);

  // an event in the clearing cycle is kept, not lost
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      count <= '0;
    end else if (clr) begin
      count <= {{(W-1){1'b0}}, inc};
    end else if (inc && !(&count)) begin
      count <= count + 1'b1;
    end
  end

endmodule : ppmrb_sat_cnt

/* ppmrb_top.sv */
// management register bank of a medium attachment unit, APB slave
//
// Register access over APB and the register offsets were decided locally.
`timescale 1ns/1ns
`include "ppmrb_defs.svh"

// Function
// - every address in the unit's space answers, unmapped ones too.
// - reserved and unsupported bits read zero; writing them changes nothing.
// - writes to undefined and read-only registers have no effect.
// - latching-low bit stays low until read, then shows live state.
// - latching-high bit stays high until read, then shows live state.
// - reset bit restores all registers to defaults, reads one meanwhile.
// - management interface works again within half a second of reset.
// - during reset, reset bit and device-present field still readable.
// - low power keeps management alive; invalid speed writes are ignored.
// - local loopback on control bit 0 if supported, else reads zero.
// - remote loopback on control bit 1 if supported, else reads zero.
// - receive link latches low; handshake types show down while initializing.
// - read-only identifier of 22 identifier bits, model and revision.
// - type select in bits 5:0; unadvertised types are ignored.
// - transmit and receive faults latch high, read zero if undetectable.
// - lane disables turn lanes off; global bit disables everything.
// - single-lane uses bit 0 only; no-disable device ignores register.
// - error counters zero for absent lanes, clear on read, saturate.
// - tone enable resets by subtype on reset or link down.
// - ignore-tones bit blocks answering handshake tones, clears on reset.
// - cleardown write issues command then clears; only in ready-down.
// - link state reads 001 init, 000 down quiet, 100 down tones.
module ppmrb_top #(
  parameter bit         HAS_LLB    = 1'b1,
  parameter bit         HAS_RLB    = 1'b1,
  parameter bit         HAS_FAULT  = 1'b1,
  parameter int         TXDIS_MODE = 2,
  parameter bit         HANDSHAKE  = 1'b1,
  parameter bit         REMOTE_SUB = 1'b0,
  parameter int         LANES      = 4,
  parameter int         NSLOT      = 4,
  parameter int         CNT_W      = 16,
  parameter logic [15:0] SPEED_OK  = 16'h0001,
  parameter logic [63:0] TYPE_ABIL = 64'h0000_0000_0000_00ff,
  parameter logic [15:0] EXT_ABIL  = 16'h0000,
  // identifier values are arbitrary
  parameter logic [21:0] ORG_ID    = 22'h2a_5a5a,
  parameter logic [5:0]  MODEL_NUM = 6'h01,
  parameter logic [3:0]  REV_NUM   = 4'h1,
  parameter int          SRST_CYC  = `PPMRB_SRST_CYC
) (
  // clock and reset
  input  wire logic              sys_clk,
  input  wire logic              rstn,
  // apb slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // line status
  input  wire logic              linkUp,
  input  wire logic              linkInit,
  input  wire logic              tonesDet,
  input  wire logic              txFaultIn,
  input  wire logic              rxFaultIn,
  input  wire logic [NSLOT-1:0]  errPulse,
  // unit controls
  output logic                   localLoop,
  output logic                   remoteLoop,
  output logic                   lowPower,
  output logic      [3:0]        speedSel,
  output logic      [5:0]        typeSel,
  output logic      [9:0]        laneTxOff,
  output logic                   txGlobalOff,
  output logic                   toneSendEn,
  output logic                   ignoreTones,
  output logic                   cleardownCmd
);

  // ----------------------------------------
  // decode
  // ----------------------------------------
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a[7:2] == off[7:2]);
  endfunction : hit

  ppmrb_pkg::ppmrb_srst_e srst_q;
  ppmrb_pkg::ppmrb_ctrl_s ctrl_q;
  ppmrb_pkg::ppmrb_hs_s   hs_q;
  ppmrb_pkg::ppmrb_link_e linkSt;
  logic [15:0]            srCnt_q;
  logic [10:0]            txDis_q;
  logic                   rxLink_q;
  logic                   retLink_q;
  logic [1:0]             flt_q;
  logic [1:0]             retFlt_q;
  logic [1:0]             fltLive;
  logic                   linkUpPrev_q;
  logic [31:0]            rdMux;
  logic [CNT_W-1:0]       errCnt [NSLOT];
  logic                   setup;
  logic                   done;
  logic                   wrDone;
  logic                   rdSetup;
  logic                   swRst;
  logic                   liveLink;
  logic                   readyDown;
  logic                   linkDownEv;

  assign setup      = psel && !penable;
  assign done       = psel && penable && pready;
  assign wrDone     = done && pwrite && !swRst;
  assign rdSetup    = setup && !pwrite;
  assign swRst      = (srst_q != ppmrb_pkg::SR_IDLE);
  assign liveLink   = linkUp && !(HANDSHAKE && linkInit);
  assign readyDown  = HANDSHAKE && !linkUp && !linkInit;
  assign linkDownEv = linkUpPrev_q && !linkUp;
  assign fltLive    = {txFaultIn, rxFaultIn} & {2{HAS_FAULT}};

  // ----------------------------------------
  // apb handshake
  // ----------------------------------------
  // fixed zero-wait answer keeps every address, mapped or not, alive
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0;
    end else begin
      pready  <= setup;
      pslverr <= 1'b0;
      if (rdSetup) begin
        prdata <= rdMux;
      end
    end
  end

  // ----------------------------------------
  // soft reset sequence
  // ----------------------------------------
  // hold time far below the half-second bound
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      srst_q  <= ppmrb_pkg::SR_IDLE;
      srCnt_q <= 16'h0;
    end else begin
      case (srst_q)
        ppmrb_pkg::SR_IDLE: begin
          if (wrDone && hit(paddr, `PPMRB_A_CTRL1) &&
              pwdata[`PPMRB_B_SRST]) begin
            srst_q  <= ppmrb_pkg::SR_HOLD;
            srCnt_q <= 16'(SRST_CYC - 1);
          end
        end
        ppmrb_pkg::SR_HOLD: begin
          if (srCnt_q == 16'h0) begin
            srst_q <= ppmrb_pkg::SR_DONE;
          end else begin
            srCnt_q <= srCnt_q - 16'h1;
          end
        end
        ppmrb_pkg::SR_DONE: begin
          srst_q <= ppmrb_pkg::SR_IDLE;
        end
        default: begin
          srst_q <= ppmrb_pkg::SR_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------
  // control registers
  // ----------------------------------------
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      ctrl_q <= '0;
    end else if (swRst) begin
      ctrl_q <= '0;
    end else if (wrDone && hit(paddr, `PPMRB_A_CTRL1)) begin
      ctrl_q.lowPwr  <= pwdata[`PPMRB_B_LPWR];
      if (SPEED_OK[pwdata[`PPMRB_F_SPEED]]) begin
        ctrl_q.speed <= pwdata[`PPMRB_F_SPEED];
      end
      ctrl_q.remLoop <= HAS_RLB && pwdata[`PPMRB_B_RLB];
      ctrl_q.locLoop <= HAS_LLB && pwdata[`PPMRB_B_LLB];
    end
  end

  assign localLoop  = ctrl_q.locLoop;
  assign remoteLoop = ctrl_q.remLoop;
  assign lowPower   = ctrl_q.lowPwr;
  assign speedSel   = ctrl_q.speed;

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      typeSel <= `PPMRB_TYPE_RST;
    end else if (swRst) begin
      typeSel <= `PPMRB_TYPE_RST;
    end else if (wrDone && hit(paddr, `PPMRB_A_CTRL2) &&
                 TYPE_ABIL[pwdata[`PPMRB_F_TYPE]]) begin
      typeSel <= pwdata[`PPMRB_F_TYPE];
    end
  end

  // ----------------------------------------
  // transmit disable
  // ----------------------------------------
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      txDis_q <= 11'h0;
    end else if (swRst) begin
      txDis_q <= 11'h0;
    end else if (wrDone && hit(paddr, `PPMRB_A_TXDIS)) begin
      if (TXDIS_MODE == 1) begin
        txDis_q <= {10'h0, pwdata[0]};
      end else if (TXDIS_MODE == 2) begin
        txDis_q <= pwdata[`PPMRB_F_TXDIS];
      end
    end
  end

  // global bit overrides, so a lane runs only when both are clear
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      laneTxOff   <= 10'h0;
      txGlobalOff <= 1'b0;
    end else begin
      laneTxOff   <= txDis_q[10:1] | {10{txDis_q[0]}};
      txGlobalOff <= txDis_q[0];
    end
  end

  // ----------------------------------------
  // latching status
  // ----------------------------------------
  // snapshot taken with the read data, release only if unchanged since
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      retLink_q <= 1'b0;
      retFlt_q  <= 2'h0;
    end else if (rdSetup) begin
      retLink_q <= rxLink_q;
      retFlt_q  <= flt_q;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      rxLink_q <= 1'b0;
    end else if (swRst) begin
      rxLink_q <= liveLink;
    end else if (done && !pwrite && hit(paddr, `PPMRB_A_STAT1) &&
                 (rxLink_q == retLink_q)) begin
      rxLink_q <= liveLink;
    end else begin
      rxLink_q <= rxLink_q && liveLink;
    end
  end

  for (genvar i = 0; i < 2; i++) begin : g_flt
    always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
        flt_q[i] <= 1'b0;
      end else if (swRst) begin
        flt_q[i] <= fltLive[i];
      end else if (done && !pwrite && hit(paddr, `PPMRB_A_STAT2) &&
                   (flt_q[i] == retFlt_q[i])) begin
        flt_q[i] <= fltLive[i];
      end else begin
        flt_q[i] <= flt_q[i] || fltLive[i];
      end
    end
  end

  // ----------------------------------------
  // handshake control
  // ----------------------------------------
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      linkUpPrev_q <= 1'b0;
    end else begin
      linkUpPrev_q <= linkUp;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      hs_q <= '{toneEn: HANDSHAKE && REMOTE_SUB, default: 1'b0};
    end else if (swRst) begin
      hs_q <= '{toneEn: HANDSHAKE && REMOTE_SUB, default: 1'b0};
    end else begin
      if (HANDSHAKE && linkDownEv) begin
        hs_q.toneEn <= REMOTE_SUB;
      end else if (HANDSHAKE && wrDone && hit(paddr, `PPMRB_A_HSCTL)) begin
        hs_q.toneEn <= pwdata[`PPMRB_B_TONE];
      end
      if (HANDSHAKE && wrDone && hit(paddr, `PPMRB_A_HSCTL)) begin
        hs_q.ignoreTones <= pwdata[`PPMRB_B_IGN];
      end
      if (hs_q.clearDown) begin
        hs_q.clearDown <= 1'b0;
      end else if (wrDone && hit(paddr, `PPMRB_A_HSCTL) &&
                   pwdata[`PPMRB_B_CLRD] && readyDown) begin
        hs_q.clearDown <= 1'b1;
      end
    end
  end

  assign toneSendEn  = hs_q.toneEn;
  assign ignoreTones = hs_q.ignoreTones;

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      cleardownCmd <= 1'b0;
    end else begin
      cleardownCmd <= hs_q.clearDown && !swRst;
    end
  end

  always_comb begin
    if (linkInit) begin
      linkSt = ppmrb_pkg::LS_INIT;
    end else if (linkUp) begin
      linkSt = ppmrb_pkg::LS_UP;
    end else if (tonesDet) begin
      linkSt = ppmrb_pkg::LS_TONES;
    end else begin
      linkSt = ppmrb_pkg::LS_DOWN;
    end
  end

  // ----------------------------------------
  // pattern error counters
  // ----------------------------------------
  for (genvar i = 0; i < NSLOT; i++) begin : g_cnt
    ppmrb_sat_cnt #(.W(CNT_W)) u_cnt (
      .sys_clk (sys_clk),
      .rstn    (rstn),
      .clr     (swRst || (rdSetup &&
                hit(paddr, 8'(`PPMRB_A_ERRC0 + 4 * i)))),
      .inc     (errPulse[i] && (i < LANES)),
      .count   (errCnt[i])
    );
  end

  // ----------------------------------------
  // read mux
  // ----------------------------------------
  // unmapped and reserved bits fall through to zero
  always_comb begin
    rdMux = 32'h0;
    if (swRst) begin
      if (hit(paddr, `PPMRB_A_CTRL1)) begin
        rdMux[`PPMRB_B_SRST] = 1'b1;
      end
      if (hit(paddr, `PPMRB_A_STAT2)) begin
        rdMux[`PPMRB_F_PRES] = `PPMRB_PRESENT;
      end
    end else if (hit(paddr, `PPMRB_A_CTRL1)) begin
      rdMux[`PPMRB_B_LPWR]  = ctrl_q.lowPwr;
      rdMux[`PPMRB_F_SPEED] = ctrl_q.speed;
      rdMux[`PPMRB_B_RLB]   = ctrl_q.remLoop;
      rdMux[`PPMRB_B_LLB]   = ctrl_q.locLoop;
    end else if (hit(paddr, `PPMRB_A_STAT1)) begin
      rdMux[`PPMRB_B_RXLINK] = rxLink_q;
      rdMux[`PPMRB_B_FAULT]  = |flt_q;
    end else if (hit(paddr, `PPMRB_A_ID1)) begin
      rdMux[15:0] = ORG_ID[21:6];
    end else if (hit(paddr, `PPMRB_A_ID2)) begin
      rdMux[15:0] = {ORG_ID[5:0], MODEL_NUM, REV_NUM};
    end else if (hit(paddr, `PPMRB_A_CTRL2)) begin
      rdMux[`PPMRB_F_TYPE] = typeSel;
    end else if (hit(paddr, `PPMRB_A_STAT2)) begin
      rdMux[`PPMRB_F_PRES] = `PPMRB_PRESENT;
      rdMux[`PPMRB_B_TXF]  = flt_q[1];
      rdMux[`PPMRB_B_RXF]  = flt_q[0];
    end else if (hit(paddr, `PPMRB_A_TXDIS)) begin
      rdMux[`PPMRB_F_TXDIS] = txDis_q;
    end else if (hit(paddr, `PPMRB_A_EXTAB)) begin
      rdMux[15:0] = EXT_ABIL;
    end else if (hit(paddr, `PPMRB_A_HSCTL)) begin
      rdMux[`PPMRB_B_TONE] = hs_q.toneEn;
      rdMux[`PPMRB_B_IGN]  = hs_q.ignoreTones;
      rdMux[`PPMRB_B_CLRD] = hs_q.clearDown;
    end else if (hit(paddr, `PPMRB_A_HSSTAT) && HANDSHAKE) begin
      rdMux[`PPMRB_F_LSTATE] = linkSt;
    end else begin
      for (int k = 0; k < NSLOT; k++) begin
        if (hit(paddr, 8'(`PPMRB_A_ERRC0 + 4 * k)) && (k < LANES)) begin
          rdMux[CNT_W-1:0] = errCnt[k];
        end
      end
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  sequence srStart;
    !swRst && wrDone && hit(paddr, `PPMRB_A_CTRL1) && pwdata[`PPMRB_B_SRST];
  endsequence

  sequence srHeld;
    swRst[*8] ##[1:20] !swRst;
  endsequence

  apb_answer_a: assert property (
    setup |=> pready ##1 !pready)
    else $error("apb answer not one cycle after setup");

  unmapped_zero_a: assert property (
    rdSetup && !swRst && paddr >= 8'(`PPMRB_A_ERRC0 + 4 * NSLOT)
    |=> prdata == 32'h0)
    else $error("unmapped read not zero");

  latch_low_a: assert property (
    !rxLink_q && !swRst && !(done && !pwrite) |=> !rxLink_q)
    else $error("latched low link released without read");

  latch_high_a: assert property (
    flt_q[1] && !swRst && !(done && !pwrite) |=> flt_q[1])
    else $error("latched transmit fault released without read");

  soft_reset_a: assert property (
    srStart |=> srHeld)
    else $error("soft reset did not hold and finish");

  reset_read_a: assert property (
    swRst && rdSetup && hit(paddr, `PPMRB_A_CTRL1)
    |=> prdata[`PPMRB_B_SRST])
    else $error("reset bit not one during reset");

  type_ignore_a: assert property (
    wrDone && hit(paddr, `PPMRB_A_CTRL2) &&
    !TYPE_ABIL[pwdata[`PPMRB_F_TYPE]] |=> $stable(typeSel))
    else $error("unadvertised type accepted");

  lane_off_a: assert property (
    txDis_q[0] |=> (&laneTxOff) && txGlobalOff)
    else $error("global disable left a lane on");

  cnt_sat_a: assert property (
    (&errCnt[0]) && !swRst && !rdSetup |=> &errCnt[0])
    else $error("error counter wrapped");

  cleardown_a: assert property (
    $rose(hs_q.clearDown) |-> $past(readyDown) ##1
    (!hs_q.clearDown && cleardownCmd))
    else $error("cleardown not issued and cleared");

endmodule : ppmrb_top

/* ppmrb_apb_master.sv */
// apb master standing in for the station management entity
`timescale 1ns/1ns
module ppmrb_apb_master (
  // clock
  input  wire logic        sys_clk,
  // apb request
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [7:0]       paddr,
  output logic [31:0]      pwdata,
  // apb answer
  input  wire logic [31:0] prdata,
  input  wire logic        pready
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
  end

  // ----------------------------------------
  // one transfer, held until pready is seen
  // ----------------------------------------
  // no wait bound here: the bench timeout catches a dead slave
  // late flags any wait state beyond the single access cycle
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] r,
                      output logic late);
    int n;
    n = 0;
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    @(posedge sys_clk);
    while (pready !== 1'b1) begin
      @(posedge sys_clk);
      n++;
    end
    late = (n != 0);
    r = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
endmodule : ppmrb_apb_master

/* ppmrb_top_test.sv */
// self-checking bench for the management register bank
`timescale 1ns/1ns
`include "ppmrb_defs.svh"
module ppmrb_top_test;
  typedef struct packed {
    logic        wr;
    logic [7:0]  addr;
    logic [15:0] wdata;
    logic [15:0] mask;
    logic [15:0] exp;
  } ppmrb_row_s;
  localparam int LIMIT = 90000;
  logic        sys_clk, rstn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, v;
  logic        linkUp, linkInit, tonesDet, txFaultIn, rxFaultIn, hit;
  logic [3:0]  errPulse, speedSel;
  logic        localLoop, remoteLoop, lowPower, txGlobalOff;
  logic        toneSendEn, ignoreTones, cleardownCmd;
  logic [5:0]  typeSel;
  logic [9:0]  laneTxOff;
  int          n_mismatch, checks, cyc, n;
  ppmrb_row_s  rows [17] = '{
    '{1'b0, `PPMRB_A_ID1, 16'h0, 16'hffff, 16'ha969},
    '{1'b0, `PPMRB_A_ID2, 16'h0, 16'hffff, 16'h6811},
    '{1'b0, `PPMRB_A_CTRL1, 16'h0, 16'hffff, 16'h0000},
    '{1'b0, `PPMRB_A_STAT2, 16'h0, 16'hffff, 16'h8000},
    '{1'b0, 8'h3c, 16'h0, 16'hffff, 16'h0000},
    '{1'b1, `PPMRB_A_ID1, 16'h0, 16'hffff, 16'ha969},
    '{1'b1, `PPMRB_A_STAT2, 16'hffff, 16'hffff, 16'h8000},
    '{1'b1, `PPMRB_A_EXTAB, 16'hffff, 16'hffff, 16'h0000},
    '{1'b1, 8'h80, 16'hffff, 16'hffff, 16'h0000},
    '{1'b1, `PPMRB_A_CTRL1, 16'h0003, 16'hffff, 16'h0003},
    '{1'b1, `PPMRB_A_CTRL1, 16'h7800, 16'h7800, 16'h0800},
    '{1'b1, `PPMRB_A_CTRL1, 16'h0004, 16'h003c, 16'h0000},
    '{1'b1, `PPMRB_A_CTRL2, 16'h0007, 16'hffff, 16'h0007},
    '{1'b1, `PPMRB_A_CTRL2, 16'h0008, 16'hffff, 16'h0007},
    '{1'b1, `PPMRB_A_TXDIS, 16'h0006, 16'hffff, 16'h0006},
    '{1'b1, `PPMRB_A_HSCTL, 16'h0002, 16'h0002, 16'h0002},
    '{1'b1, `PPMRB_A_HSSTAT, 16'hffff, 16'hffff, 16'h0000}
  };

  ppmrb_top dut (
    .sys_clk(sys_clk), .rstn(rstn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .linkUp(linkUp),
    .linkInit(linkInit), .tonesDet(tonesDet), .txFaultIn(txFaultIn),
    .rxFaultIn(rxFaultIn), .errPulse(errPulse), .localLoop(localLoop),
    .remoteLoop(remoteLoop), .lowPower(lowPower), .speedSel(speedSel),
    .typeSel(typeSel), .laneTxOff(laneTxOff), .txGlobalOff(txGlobalOff),
    .toneSendEn(toneSendEn), .ignoreTones(ignoreTones),
    .cleardownCmd(cleardownCmd)
  );

  ppmrb_apb_master mst (
    .sys_clk(sys_clk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready)
  );

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic acc(input logic w, input logic [7:0] a,
                     input logic [15:0] d, output logic [31:0] r);
    logic late;
    mst.xfer(w, a, {16'h0, d}, r, late);
    chk("pready", {31'h0, late}, 32'h0);
    chk("pslverr", {31'h0, pslverr}, 32'h0);
  endtask : acc

  task automatic rdm(input logic [7:0] a, input logic [15:0] m, e);
    logic [31:0] r;
    acc(1'b0, a, 16'h0, r);
    chk("read", r & {16'h0, m}, {16'h0, e});
  endtask : rdm

  task automatic summarize;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : summarize

  initial sys_clk = 1'b0;
  always #10 sys_clk = ~sys_clk;

  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == LIMIT) begin
      n_mismatch++;
      summarize();
    end
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    {rstn, linkUp, linkInit, tonesDet, txFaultIn, rxFaultIn} = 6'h00;
    errPulse = 4'h0;
    repeat (10) @(posedge sys_clk);
    rstn <= 1'b1;
    chk("outs", {30'h0, localLoop, cleardownCmd}, 32'h0);
    foreach (rows[i]) begin
      if (rows[i].wr)
        acc(1'b1, rows[i].addr, rows[i].wdata, v);
      rdm(rows[i].addr, rows[i].mask, rows[i].exp);
    end
    repeat (2) @(posedge sys_clk);
    chk("lanes", {28'h0, laneTxOff[3:0]}, 32'h3);
    chk("type", {26'h0, typeSel}, 32'h7);
    chk("ign", {31'h0, ignoreTones}, 32'h1);
    acc(1'b1, `PPMRB_A_TXDIS, 16'h0001, v);
    repeat (2) @(posedge sys_clk);
    chk("global", {27'h0, txGlobalOff, laneTxOff[3:0]}, 32'h1f);
    // link latches low until read
    linkUp <= 1'b1;
    rdm(`PPMRB_A_STAT1, 16'h0004, 16'h0000);
    rdm(`PPMRB_A_STAT1, 16'h0004, 16'h0004);
    linkUp <= 1'b0;
    @(posedge sys_clk);
    linkUp <= 1'b1;
    rdm(`PPMRB_A_STAT1, 16'h0004, 16'h0000);
    rdm(`PPMRB_A_STAT1, 16'h0004, 16'h0004);
    // faults latch high until read
    txFaultIn <= 1'b1;
    @(posedge sys_clk);
    txFaultIn <= 1'b0;
    rdm(`PPMRB_A_STAT1, 16'h0080, 16'h0080);
    rdm(`PPMRB_A_STAT2, 16'hffff, 16'h8800);
    rdm(`PPMRB_A_STAT2, 16'hffff, 16'h8000);
    rxFaultIn <= 1'b1;
    @(posedge sys_clk);
    rxFaultIn <= 1'b0;
    rdm(`PPMRB_A_STAT2, 16'hffff, 16'h8400);
    // error counters: count, clear on read, saturate
    errPulse <= 4'h1;
    repeat (3) @(posedge sys_clk);
    errPulse <= 4'h0;
    rdm(`PPMRB_A_ERRC0, 16'hffff, 16'h0003);
    rdm(`PPMRB_A_ERRC0, 16'hffff, 16'h0000);
    rdm(8'h2c, 16'hffff, 16'h0000);
    errPulse <= 4'h5;
    repeat (65540) @(posedge sys_clk);
    errPulse <= 4'h0;
    rdm(`PPMRB_A_ERRC0, 16'hffff, 16'hffff);
    rdm(8'h30, 16'hffff, 16'hffff);
    // tone enable, then link state codes
    acc(1'b1, `PPMRB_A_HSCTL, 16'h0001, v);
    repeat (2) @(posedge sys_clk);
    chk("tone", {31'h0, toneSendEn}, 32'h1);
    linkUp <= 1'b0;
    linkInit <= 1'b1;
    repeat (3) @(posedge sys_clk);
    chk("tone", {31'h0, toneSendEn}, 32'h0);
    rdm(`PPMRB_A_HSSTAT, 16'h0007, 16'h0001);
    linkUp <= 1'b1;
    rdm(`PPMRB_A_STAT1, 16'h0004, 16'h0000);
    rdm(`PPMRB_A_STAT1, 16'h0004, 16'h0000);
    linkUp <= 1'b0;
    linkInit <= 1'b0;
    tonesDet <= 1'b1;
    rdm(`PPMRB_A_HSSTAT, 16'h0007, 16'h0004);
    tonesDet <= 1'b0;
    rdm(`PPMRB_A_HSSTAT, 16'h0007, 16'h0000);
    // cleardown only in ready link-down
    acc(1'b1, `PPMRB_A_HSCTL, 16'h0004, v);
    n = 0;
    while (cleardownCmd !== 1'b1 && n < 8) begin
      @(posedge sys_clk);
      n++;
    end
    chk("clrd", {31'h0, cleardownCmd === 1'b1}, 32'h1);
    rdm(`PPMRB_A_HSCTL, 16'h0004, 16'h0000);
    linkUp <= 1'b1;
    acc(1'b1, `PPMRB_A_HSCTL, 16'h0004, v);
    hit = 1'b0;
    repeat (8) begin
      @(posedge sys_clk);
      if (cleardownCmd !== 1'b0)
        hit = 1'b1;
    end
    chk("clrd", {31'h0, hit}, 32'h0);
    acc(1'b1, `PPMRB_A_CTRL1, 16'h0803, v);
    @(posedge sys_clk);
    chk("ctl", {25'h0, lowPower, remoteLoop, localLoop, speedSel},
        32'h70);
    // soft reset
    acc(1'b1, `PPMRB_A_CTRL2, 16'h0005, v);
    acc(1'b1, `PPMRB_A_CTRL1, 16'h8003, v);
    rdm(`PPMRB_A_CTRL1, 16'h8000, 16'h8000);
    rdm(`PPMRB_A_STAT2, 16'hc000, 16'h8000);
    n = 0;
    v = 32'h8000;
    while (v[15] !== 1'b0 && n < 50) begin
      acc(1'b0, `PPMRB_A_CTRL1, 16'h0, v);
      n++;
    end
    chk("srst", {31'h0, v[15]}, 32'h0);
    rdm(`PPMRB_A_CTRL1, 16'hffff, 16'h0000);
    rdm(`PPMRB_A_CTRL2, 16'hffff, 16'h0000);
    chk("defaults", {6'h0, lowPower, remoteLoop, localLoop, speedSel,
        typeSel, laneTxOff, txGlobalOff, toneSendEn, ignoreTones},
        32'h0);
    summarize();
  end
endmodule : ppmrb_top_test
